// *** logic/ppr_consts.vh ***
// constants for the peripheral pin remap unit
`ifndef PPR_CONSTS_VH
`define PPR_CONSTS_VH

// word indexes on the register bus (byte address = 4 * index)
`define PPR_IN_SEL_BASE     7'h00
`define PPR_IN_SEL_COUNT    7'h18
`define PPR_OUT_SEL_BASE    7'h20
`define PPR_OUT_SEL_COUNT   7'h20
`define PPR_CFG_CTRL_IDX    7'h40
`define PPR_UNLOCK_KEY_IDX  7'h41
`define PPR_BOOT_CFG3_IDX   7'h42

// field positions
`define PPR_LOCK_BIT        13
`define PPR_ONE_SHOT_BIT    29

// reset values
`define PPR_SEL_RESET       4'h0
`define PPR_LOCK_RESET      1'b0
`define PPR_ONE_SHOT_RESET  1'b1

// unlock key value, arbitrary
`define PPR_UNLOCK_KEY      32'hA5C3_5A3C

// level fed to a peripheral input whose selector is reserved
`define PPR_INACTIVE_LEVEL  1'b0

// device variant straps
`define PPR_USB_VARIANT     1'b0
`define PPR_PIN44_VARIANT   1'b1

// output selector codes
`define PPR_OUT_NONE        4'h0
`define PPR_OUT_CODE1       4'h1
`define PPR_OUT_CODE2       4'h2
`define PPR_OUT_CODE3       4'h3
`define PPR_OUT_CODE4       4'h4
`define PPR_OUT_CODE5       4'h5
`define PPR_OUT_CODE6       4'h6
`define PPR_OUT_CODE7       4'h7

// pins without an output selector (input-only remappable pins)
`define PPR_PIN_B4_IDX      5'h02
`define PPR_PIN_A4_IDX      5'h12
// pins missing on USB variants
`define PPR_PIN_B11_IDX     5'h0B
`define PPR_PIN_B6_IDX      5'h11
`define PPR_PIN_B10_IDX     5'h1B
// within a group, codes from this one up sit on 44-pin-only pins
`define PPR_PIN44_FIRST     3'h5

`endif

// *** logic/ppr_pin_remap_unit.v ***
// peripheral pin remap crossbar with avalon-mm register slave
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps
`include "ppr_consts.vh"

module ppr_pin_remap_unit (
    input  wire        clock,
    input  wire        reset,
    input  wire [8:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [3:0]  byteenable,
    input  wire [31:0] writedata,
    output wire [31:0] readdata,
    output wire        waitrequest,
    input  wire        oneShotLockOpt,
    input  wire [31:0] pinIn,
    input  wire [31:0] portLatch,
    input  wire [31:0] portOutEn,
    input  wire [31:0] analogSel,
    output wire [31:0] pinOut,
    output wire [31:0] pinOutEn,
    input  wire        uart1Transmit,
    input  wire        uart2RequestToSend,
    input  wire        spi1SelectOut,
    input  wire        usbBusPowerEnable,
    input  wire        compareOut1,
    input  wire        compareOut2,
    input  wire        compareOut3,
    input  wire        compareOut4,
    input  wire        compareOut5,
    input  wire        comparator1Result,
    input  wire        comparator2Result,
    input  wire        comparator3Result,
    input  wire        spi1DataOut,
    input  wire        spi2DataOut,
    input  wire        refClockOut,
    input  wire        uart1RequestToSend,
    input  wire        uart2Transmit,
    input  wire        spi2SelectOut,
    output wire        extIrq4,
    output wire        timer2ClockIn,
    output wire        captureInput4,
    output wire        spi1Select,
    output wire        refClockIn,
    output wire        extIrq3,
    output wire        timer3ClockIn,
    output wire        captureInput3,
    output wire        uart1ClearToSend,
    output wire        uart2Receive,
    output wire        spi1DataIn,
    output wire        extIrq2,
    output wire        timer4ClockIn,
    output wire        captureInput1,
    output wire        captureInput5,
    output wire        uart1Receive,
    output wire        uart2ClearToSend,
    output wire        spi2DataIn,
    output wire        compareFaultB,
    output wire        extIrq1,
    output wire        timer5ClockIn,
    output wire        captureInput2,
    output wire        spi2Select,
    output wire        compareFaultA
);

    reg  [3:0]  inSel_r [0:23];
    reg  [3:0]  outSel_r [0:31];
    reg         lock_r, unlockArm_r, optMeta_r, optSync_r, waitReq_r, remapDrive;
    reg  [31:0] pinMeta_r, pinSync_r, pinOut_r, pinOutNxt, pinOutEn_r, pinOutEnNxt;
    reg  [31:0] readdata_r, rdNxt;
    reg  [23:0] periphIn_r;
    reg  [23:0] periphInNxt;
    reg  [3:0]  inCode;
    reg  [4:0]  inIdx;
    reg  [1:0]  muxRes;
    integer     i;
    // separate loop index so the crossbar and the selector reset never share a driver
    integer     j;

    wire [6:0]  wordIdx = address[8:2];
    wire        wrTake  = write && !waitReq_r;
    wire        selWrOk = wrTake && !lock_r && byteenable[0];
    wire [17:0] periphBus = {spi2SelectOut, uart2Transmit, uart1RequestToSend, refClockOut,
                             spi2DataOut, spi1DataOut, comparator3Result, comparator2Result,
                             comparator1Result, compareOut5, compareOut4, compareOut3,
                             compareOut2, compareOut1, usbBusPowerEnable, spi1SelectOut,
                             uart2RequestToSend, uart1Transmit};

    // group of a peripheral input, in the order of the input selector registers
    function [1:0] inGroup;
        input [4:0] idx;
        begin
            if (idx < 5'h05)
                inGroup = 2'h0;
            else if (idx < 5'h0B)
                inGroup = 2'h1;
            else if (idx < 5'h13)
                inGroup = 2'h2;
            else
                inGroup = 2'h3;
        end
    endfunction

    // a pin index is group * 8 + its input decode code
    function pinPresent;
        input [4:0] idx;
        begin
            pinPresent = 1'b1;
            if (!`PPR_PIN44_VARIANT && idx[2:0] >= `PPR_PIN44_FIRST)
                pinPresent = 1'b0;
            if (`PPR_USB_VARIANT && (idx == `PPR_PIN_B11_IDX || idx == `PPR_PIN_B6_IDX
                                     || idx == `PPR_PIN_B10_IDX))
                pinPresent = 1'b0;
        end
    endfunction

    function hasOutSel;
        input [4:0] idx;
        begin
            hasOutSel = pinPresent(idx) && idx != `PPR_PIN_B4_IDX && idx != `PPR_PIN_A4_IDX;
        end
    endfunction

    // returns {connected, level}; reserved codes and code zero connect nothing
    function [1:0] outMux;
        input [1:0]  grp;
        input [3:0]  code;
        input [17:0] bus;
        begin
            outMux = 2'h0;
            case (grp)
                2'h0:
                begin
                    case (code)
                        `PPR_OUT_CODE1: outMux = {1'b1, bus[0]};
                        `PPR_OUT_CODE2: outMux = {1'b1, bus[1]};
                        `PPR_OUT_CODE3: outMux = {1'b1, bus[2]};
                        `PPR_OUT_CODE4: outMux = {`PPR_USB_VARIANT, bus[3]};
                        `PPR_OUT_CODE5: outMux = {1'b1, bus[4]};
                        `PPR_OUT_CODE7: outMux = {1'b1, bus[10]};
                        default:        outMux = 2'h0;
                    endcase
                end
                2'h1:
                begin
                    case (code)
                        `PPR_OUT_CODE3: outMux = {1'b1, bus[12]};
                        `PPR_OUT_CODE4: outMux = {1'b1, bus[13]};
                        `PPR_OUT_CODE5: outMux = {1'b1, bus[5]};
                        `PPR_OUT_CODE7: outMux = {1'b1, bus[11]};
                        default:        outMux = 2'h0;
                    endcase
                end
                2'h2:
                begin
                    case (code)
                        `PPR_OUT_CODE3: outMux = {1'b1, bus[12]};
                        `PPR_OUT_CODE4: outMux = {1'b1, bus[13]};
                        `PPR_OUT_CODE5: outMux = {1'b1, bus[7]};
                        `PPR_OUT_CODE6: outMux = {1'b1, bus[8]};
                        `PPR_OUT_CODE7: outMux = {1'b1, bus[14]};
                        default:        outMux = 2'h0;
                    endcase
                end
                default:
                begin
                    case (code)
                        `PPR_OUT_CODE1: outMux = {1'b1, bus[15]};
                        `PPR_OUT_CODE2: outMux = {1'b1, bus[16]};
                        `PPR_OUT_CODE4: outMux = {1'b1, bus[17]};
                        `PPR_OUT_CODE5: outMux = {1'b1, bus[6]};
                        `PPR_OUT_CODE7: outMux = {1'b1, bus[9]};
                        default:        outMux = 2'h0;
                    endcase
                end
            endcase
        end
    endfunction

    // pins and the option strap come from outside this clock domain
    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            pinMeta_r <= 32'h0;
            pinSync_r <= 32'h0;
            optMeta_r <= `PPR_ONE_SHOT_RESET;
            optSync_r <= `PPR_ONE_SHOT_RESET;
        end
        else
        begin
            pinMeta_r <= pinIn;
            pinSync_r <= pinMeta_r;
            optMeta_r <= oneShotLockOpt;
            optSync_r <= optMeta_r;
        end
    end

    // crossbar, input side per peripheral and output side per pin
    always @*
    begin
        inCode      = 4'h0;
        inIdx       = 5'h0;
        muxRes      = 2'h0;
        remapDrive  = 1'b0;
        periphInNxt = 24'h0;
        pinOutNxt   = 32'h0;
        pinOutEnNxt = 32'h0;
        for (i = 0; i < 24; i = i + 1)
        begin
            inCode = inSel_r[i];
            inIdx  = {inGroup(i[4:0]), inCode[2:0]};
            if (!inCode[3] && pinPresent(inIdx))
                periphInNxt[i] = pinSync_r[inIdx];
            else
                periphInNxt[i] = `PPR_INACTIVE_LEVEL;
        end
        for (i = 0; i < 32; i = i + 1)
        begin
            muxRes     = outMux(i[4:3], outSel_r[i], periphBus);
            remapDrive = muxRes[1] && hasOutSel(i[4:0]) && !analogSel[i];
            if (remapDrive)
            begin
                pinOutNxt[i]   = muxRes[0];
                pinOutEnNxt[i] = 1'b1;
            end
            else
            begin
                pinOutNxt[i]   = portLatch[i];
                pinOutEnNxt[i] = portOutEn[i];
            end
        end
    end

    always @*
    begin
        rdNxt = 32'h0;
        if (wordIdx < `PPR_IN_SEL_COUNT)
            rdNxt = {28'h0, inSel_r[wordIdx[4:0]]};
        else if (wordIdx >= `PPR_OUT_SEL_BASE && wordIdx < `PPR_CFG_CTRL_IDX)
            rdNxt = {28'h0, outSel_r[wordIdx[4:0]]};
        else if (wordIdx == `PPR_CFG_CTRL_IDX)
            rdNxt[`PPR_LOCK_BIT] = lock_r;
        else if (wordIdx == `PPR_BOOT_CFG3_IDX)
            rdNxt[`PPR_ONE_SHOT_BIT] = optSync_r;
    end

    // every access gets exactly one wait cycle, which keeps readdata a flop output
    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            waitReq_r  <= 1'b1;
            readdata_r <= 32'h0;
        end
        else
        begin
            waitReq_r <= !((read || write) && waitReq_r);
            if (read && waitReq_r)
                readdata_r <= rdNxt;
        end
    end

    // lock and unlock arming; any other write between key and config disarms
    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            lock_r      <= `PPR_LOCK_RESET;
            unlockArm_r <= 1'b0;
        end
        else if (wrTake)
        begin
            unlockArm_r <= wordIdx == `PPR_UNLOCK_KEY_IDX && writedata == `PPR_UNLOCK_KEY;
            if (wordIdx == `PPR_CFG_CTRL_IDX && unlockArm_r && byteenable[1])
            begin
                if (writedata[`PPR_LOCK_BIT] || !(lock_r && optSync_r))
                    lock_r <= writedata[`PPR_LOCK_BIT];
            end
        end
    end

    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            for (j = 0; j < 24; j = j + 1)
                inSel_r[j] <= `PPR_SEL_RESET;
            for (j = 0; j < 32; j = j + 1)
                outSel_r[j] <= `PPR_SEL_RESET;
        end
        else if (selWrOk)
        begin
            if (wordIdx < `PPR_IN_SEL_COUNT)
                inSel_r[wordIdx[4:0]] <= writedata[3:0];
            else if (wordIdx >= `PPR_OUT_SEL_BASE && wordIdx < `PPR_CFG_CTRL_IDX
                     && hasOutSel(wordIdx[4:0]))
                outSel_r[wordIdx[4:0]] <= writedata[3:0];
        end
    end

    always @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            periphIn_r <= {24{`PPR_INACTIVE_LEVEL}};
            pinOut_r   <= 32'h0;
            pinOutEn_r <= 32'h0;
        end
        else
        begin
            periphIn_r <= periphInNxt;
            pinOut_r   <= pinOutNxt;
            pinOutEn_r <= pinOutEnNxt;
        end
    end

    assign readdata         = readdata_r;
    assign waitrequest      = waitReq_r;
    assign pinOut           = pinOut_r;
    assign pinOutEn         = pinOutEn_r;
    assign extIrq4          = periphIn_r[0];
    assign timer2ClockIn    = periphIn_r[1];
    assign captureInput4    = periphIn_r[2];
    assign spi1Select       = periphIn_r[3];
    assign refClockIn       = periphIn_r[4];
    assign extIrq3          = periphIn_r[5];
    assign timer3ClockIn    = periphIn_r[6];
    assign captureInput3    = periphIn_r[7];
    assign uart1ClearToSend = periphIn_r[8];
    assign uart2Receive     = periphIn_r[9];
    assign spi1DataIn       = periphIn_r[10];
    assign extIrq2          = periphIn_r[11];
    assign timer4ClockIn    = periphIn_r[12];
    assign captureInput1    = periphIn_r[13];
    assign captureInput5    = periphIn_r[14];
    assign uart1Receive     = periphIn_r[15];
    assign uart2ClearToSend = periphIn_r[16];
    assign spi2DataIn       = periphIn_r[17];
    assign compareFaultB    = periphIn_r[18];
    assign extIrq1          = periphIn_r[19];
    assign timer5ClockIn    = periphIn_r[20];
    assign captureInput2    = periphIn_r[21];
    assign spi2Select       = periphIn_r[22];
    assign compareFaultA    = periphIn_r[23];

endmodule // ppr_pin_remap_unit

// *** verification/ppr_pin_remap_unit_sva.sv ***
// assertion checker for the remap unit bus handshake and pin drive
`timescale 1ns/1ps
module ppr_pin_remap_unit_chk (
    input logic        clock,
    input logic        reset,
    input logic [8:0]  address,
    input logic        read,
    input logic        write,
    input logic [31:0] readdata,
    input logic        waitrequest,
    input logic [31:0] portLatch,
    input logic [31:0] portOutEn,
    input logic [31:0] analogSel,
    input logic [31:0] pinOut,
    input logic [31:0] pinOutEn
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    wire       rdTake = read && !waitrequest;
    wire [6:0] word   = address[8:2];

    chk_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("waitrequest stayed high after the wait cycle");
    chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_wait_idle: assert property (!read && !write |=> waitrequest)
        else $error("waitrequest low without a request");
    chk_key_read: assert property (rdTake && word == 7'h41 |-> readdata == 32'h0)
        else $error("unlock key word reads nonzero");
    chk_option_view: assert property (rdTake && word == 7'h42 |->
        (readdata & 32'hDFFF_FFFF) == 32'h0)
        else $error("boot word view has stray bits");
    chk_cfg_bits: assert property (rdTake && word == 7'h40 |->
        (readdata & 32'hFFFF_DFFF) == 32'h0)
        else $error("config control has stray bits");
    chk_sel_width: assert property (rdTake && word < 7'h40 |-> readdata[31:4] == 28'h0)
        else $error("selector reads wider than four bits");
    chk_unmapped_read: assert property (rdTake && word > 7'h42 |-> readdata == 32'h0)
        else $error("unmapped word reads nonzero");
    // analog pins keep the port drive whatever the selector says
    chk_analog_port: assert property (!$past(reset) |->
        (((pinOut ^ $past(portLatch)) | (pinOutEn ^ $past(portOutEn))) & $past(analogSel)) == 0)
        else $error("remap overrode an analog pin");

    cover property (write && !waitrequest && word == 7'h40);
    cover property (rdTake && readdata[13]);
    cover property (|analogSel && |pinOut);
endmodule // ppr_pin_remap_unit_chk

bind ppr_pin_remap_unit ppr_pin_remap_unit_chk u_chk (.clock(clock), .reset(reset),
    .address(address), .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .portLatch(portLatch), .portOutEn(portOutEn),
    .analogSel(analogSel), .pinOut(pinOut), .pinOutEn(pinOutEn));

// *** verification/ppr_periph_model.sv ***
// model of the on-chip peripherals and the pins around the remap unit
`timescale 1ns/1ps
module ppr_periph_model (
    input  logic        clock,
    input  logic [4:0]  periPick,
    input  logic [5:0]  pinPick,
    output logic [17:0] periOut,
    output logic [31:0] pinLevel
);
    // one peripheral output high at a time, so a wrong route reads low
    always @(posedge clock)
    begin
        periOut  <= (periPick < 5'h12) ? 18'h1 << periPick : 18'h0;
        pinLevel <= pinPick[5] ? {32{~pinPick[0]}} : 32'h1 << pinPick[4:0];
    end
endmodule // ppr_periph_model

// *** verification/ppr_pin_remap_unit_bench.sv ***
// self-checking bench for the pin remap unit
`timescale 1ns/1ps
`include "ppr_consts.vh"
`define PPR_CHECK(nm, exp, got) begin checksDone++; if ((got) !== (exp)) begin errCount++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module ppr_pin_remap_unit_bench;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [8:0]  address = 9'h000;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic        oneShotLockOpt = 1'b1;
    logic [31:0] portLatch = 32'h0;
    logic [31:0] portOutEn = 32'h0;
    logic [31:0] analogSel = 32'h0;
    logic [4:0]  periPick = 5'h1F;
    logic [5:0]  pinPick = 6'h21;
    wire  [31:0] readdata;
    wire         waitrequest;
    wire  [31:0] pinOut;
    wire  [31:0] pinOutEn;
    wire  [17:0] po;
    wire  [31:0] pinLevel;
    wire  [23:0] pi;
    int          errCount;
    int          checksDone;
    int          inIdx [4] = '{0, 9, 15, 19};
    byte         outMap [4][8] = '{'{31, 0, 1, 2, 31, 4, 31, 10}, '{31, 31, 31, 12, 13, 5, 31, 11},
                                   '{31, 31, 31, 12, 13, 7, 8, 14}, '{31, 15, 16, 31, 17, 6, 31, 9}};
    logic [23:0] grpMask [4] = '{24'h00_001F, 24'h00_07E0, 24'h07_F800, 24'hF8_0000};

    always #12.5 clock = ~clock;

    ppr_periph_model model (.clock(clock), .periPick(periPick), .pinPick(pinPick),
        .periOut(po), .pinLevel(pinLevel));

    ppr_pin_remap_unit dut (.clock(clock), .reset(reset), .address(address), .read(read),
        .write(write), .byteenable(4'hF), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .oneShotLockOpt(oneShotLockOpt), .pinIn(pinLevel),
        .portLatch(portLatch), .portOutEn(portOutEn), .analogSel(analogSel),
        .pinOut(pinOut), .pinOutEn(pinOutEn), .uart1Transmit(po[0]),
        .uart2RequestToSend(po[1]), .spi1SelectOut(po[2]), .usbBusPowerEnable(po[3]),
        .compareOut1(po[4]), .compareOut2(po[5]), .compareOut3(po[6]), .compareOut4(po[7]),
        .compareOut5(po[8]), .comparator1Result(po[9]), .comparator2Result(po[10]),
        .comparator3Result(po[11]), .spi1DataOut(po[12]), .spi2DataOut(po[13]),
        .refClockOut(po[14]), .uart1RequestToSend(po[15]), .uart2Transmit(po[16]),
        .spi2SelectOut(po[17]), .extIrq4(pi[0]), .timer2ClockIn(pi[1]),
        .captureInput4(pi[2]), .spi1Select(pi[3]), .refClockIn(pi[4]), .extIrq3(pi[5]),
        .timer3ClockIn(pi[6]), .captureInput3(pi[7]), .uart1ClearToSend(pi[8]),
        .uart2Receive(pi[9]), .spi1DataIn(pi[10]), .extIrq2(pi[11]), .timer4ClockIn(pi[12]),
        .captureInput1(pi[13]), .captureInput5(pi[14]), .uart1Receive(pi[15]),
        .uart2ClearToSend(pi[16]), .spi2DataIn(pi[17]), .compareFaultB(pi[18]),
        .extIrq1(pi[19]), .timer5ClockIn(pi[20]), .captureInput2(pi[21]),
        .spi2Select(pi[22]), .compareFaultA(pi[23]));

    task automatic stopTest();
        $display("checks %0d errors %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic waitN(input int n);
        repeat (n) @(posedge clock);
    endtask

    // request held until the edge that samples waitrequest low
    task automatic busOp(input logic wr, input logic [8:0] a, input logic [31:0] d,
                         output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 50);
        if (waitrequest !== 1'b0)
        begin
            errCount++;
            stopTest();
        end
        else
        begin
            q = readdata;
            read <= 1'b0;
            write <= 1'b0;
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        logic [31:0] q;
        busOp(1'b1, a, d, q);
    endtask

    task automatic rdChk(input logic [8:0] a, input logic [31:0] e);
        logic [31:0] q;
        busOp(1'b0, a, 32'h0, q);
        `PPR_CHECK("readdata", e, q)
    endtask

    task automatic setLock(input logic v);
        wr(9'h104, `PPR_UNLOCK_KEY);
        wr(9'h100, {18'h0, v, 13'h0});
    endtask

    task automatic doReset();
        reset <= 1'b1;
        waitN(6);
        reset <= 1'b0;
    endtask

    initial
    begin
        errCount = 0;
        checksDone = 0;
        doReset();
        rdChk(9'h000, 32'h0);
        rdChk(9'h080, 32'h0);
        rdChk(9'h100, 32'h0);
        rdChk(9'h108, 32'h2000_0000);
        rdChk(9'h104, 32'h0);
        rdChk(9'h1F0, 32'h0);
        for (int g = 0; g < 4; g++)
            for (int c = 0; c < 9; c++)
            begin
                wr(9'(4 * inIdx[g]), 32'(c));
                rdChk(9'(4 * inIdx[g]), 32'(c));
                pinPick <= (c == 8) ? 6'h20 : 6'(8 * g + c);
                waitN(5);
                `PPR_CHECK("peripheral input", 1'(c < 8), pi[inIdx[g]])
            end
        // every input selector on code 3, then one group's code-3 pin high at a time
        for (int k = 0; k < 24; k++)
            wr(9'(4 * k), 32'h3);
        for (int g = 0; g < 4; g++)
        begin
            pinPick <= 6'(8 * g + 3);
            waitN(5);
            `PPR_CHECK("all peripheral inputs", grpMask[g], pi)
        end
        portLatch <= 32'hFFFF_FFFF;
        for (int g = 0; g < 4; g++)
            for (int c = 0; c < 9; c++)
            begin
                wr(9'h080 + 9'(32 * g), 32'(c));
                for (int s = 0; s < 2; s++)
                begin
                    logic p;
                    p = c < 8 && outMap[g][c % 8] != 31;
                    periPick <= s ? 5'(outMap[g][c % 8]) : 5'h1F;
                    waitN(3);
                    `PPR_CHECK("pinOut", 1'(p ? s : 1), pinOut[8 * g])
                    `PPR_CHECK("pinOutEn", p, pinOutEn[8 * g])
                end
            end
        // every output selector on code 5; B4 and A4 have none and keep the latch
        for (int k = 0; k < 32; k++)
            wr(9'h080 + 9'(4 * k), 32'h5);
        for (int g = 0; g < 4; g++)
        begin
            periPick <= 5'(outMap[g][5]);
            waitN(3);
            `PPR_CHECK("all pin drive", 32'hFFFB_FFFB, pinOutEn)
            `PPR_CHECK("all pin levels", (32'hFF << 8 * g) | 32'h0004_0004, pinOut)
        end
        wr(9'h080, 32'h1);
        periPick <= 5'h1F;
        analogSel <= 32'h1;
        portOutEn <= 32'h1;
        waitN(3);
        `PPR_CHECK("analog pin", 2'b11, {pinOutEn[0], pinOut[0]})
        analogSel <= 32'h0;
        wr(9'h088, 32'h3);
        rdChk(9'h088, 32'h0);
        wr(9'h100, 32'h2000);
        rdChk(9'h100, 32'h0);
        setLock(1'b1);
        rdChk(9'h100, 32'h2000);
        wr(9'h000, 32'h5);
        rdChk(9'h000, 32'h3);
        setLock(1'b0);
        rdChk(9'h100, 32'h2000);
        doReset();
        rdChk(9'h100, 32'h0);
        rdChk(9'h000, 32'h0);
        oneShotLockOpt <= 1'b0;
        waitN(3);
        rdChk(9'h108, 32'h0);
        setLock(1'b1);
        setLock(1'b0);
        rdChk(9'h100, 32'h0);
        wr(9'h000, 32'h3);
        rdChk(9'h000, 32'h3);
        stopTest();
    end
endmodule // ppr_pin_remap_unit_bench
